// file: synth_voice_pkg.sv
`default_nettype none
package synth_voice_pkg;
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned VOICES = 4;
  localparam int unsigned RAMPS_PER_VOICE = 6;
  localparam int unsigned RAMP_COUNT = 24;
  localparam int unsigned MOD_COUNT = 32;
  localparam int unsigned SAMPLES = 32;
  localparam int unsigned USER_SLOTS = 32;
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STOP = 8'h04;
  localparam logic [7:0] ADDR_SKIP = 8'h08;
  localparam logic [7:0] ADDR_WSEL = 8'h0C;
  localparam logic [7:0] ADDR_WADDR = 8'h10;
  localparam logic [7:0] ADDR_WDATA = 8'h14;
  localparam logic [7:0] ADDR_RAMP = 8'h18;
  localparam logic [7:0] ADDR_TIMER = 8'h1C;
  localparam logic [7:0] ADDR_PATCH = 8'h20;
  localparam logic [7:0] ADDR_DONE = 8'h24;
  localparam logic [7:0] ADDR_NONE = 8'hFF;
  // Field positions
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned CTRL_RESUME_BIT = 1;
  localparam int unsigned CTRL_HALT_BIT = 2;
  localparam int unsigned WSEL_A_BIT = 8;
  localparam int unsigned WSEL_B_BIT = 9;
  localparam int unsigned VOICE_LSB = 12;
  localparam int unsigned WADDR_SLOT_LSB = 6;
  localparam int unsigned RAMP_SPD_LSB = 4;
  localparam int unsigned RAMP_PAR_LSB = 8;
  localparam int unsigned TIMER_VOICE_LSB = 16;
  localparam int unsigned PATCH_WM_LSB = 4;
  localparam int unsigned DONE_TIMER_LSB = 24;
  // Parameter numbers inside a voice; module number = voice*8 + parameter
  localparam logic [2:0] P_MIX = 3'h0;
  localparam logic [2:0] P_CUT = 3'h1;
  localparam logic [2:0] P_TRN = 3'h2;
  localparam logic [2:0] P_VOL = 3'h3;
  localparam logic [2:0] P_X = 3'h4;
  localparam logic [2:0] P_Y = 3'h5;
  localparam logic [2:0] P_TMR = 3'h6;
  localparam logic [5:0] WAVE_NOISE = 6'h3F;
  localparam logic [5:0] WAVE_RANDOM = 6'h3E;
  localparam logic [3:0] LEVEL_MAX = 4'hF;
  localparam logic [3:0] MIX_CENTRE = 4'h7;
  // Fixed complex shape, 32 samples of 4 bits
  localparam logic [127:0] RANDOM_SHAPE = 128'h3A9F_1C64_E2B8_5D07_F4A1_6C93_2EB5_870D;
  // Timing
  localparam int unsigned RAMP_BASE_NS = 10_000;
  localparam int unsigned RAMP_BASE_CYC = RAMP_BASE_NS * (CLK_HZ / 1_000_000) / 1000;
  localparam int unsigned TIMER_STEP_NS = 10_000_000;
  localparam int unsigned TIMER_STEP_CYC = (TIMER_STEP_NS / 1000) * (CLK_HZ / 1_000_000);
  localparam int unsigned POLL_RATE_HZ = 4_000_000;
  localparam int unsigned POLL_CYC = CLK_HZ / POLL_RATE_HZ;
  // Base ticks per level step = 100000 / (levels per second)
  localparam int unsigned CENTI_TICKS = 100 * (1_000_000_000 / RAMP_BASE_NS);
  localparam logic [16:0] RAMP_PERIOD [16] = '{
    17'(CENTI_TICKS / 150), 17'(CENTI_TICKS / 240), 17'(CENTI_TICKS / 375),
    17'(CENTI_TICKS / 600), 17'(CENTI_TICKS / 945), 17'(CENTI_TICKS / 1500),
    17'(CENTI_TICKS / 2400), 17'(CENTI_TICKS / 3750), 17'(CENTI_TICKS / 6000),
    17'(CENTI_TICKS / 9450), 17'(CENTI_TICKS / 15000), 17'(CENTI_TICKS / 24000),
    17'(CENTI_TICKS / 37500), 17'(CENTI_TICKS / 60000), 17'(CENTI_TICKS / 94500),
    17'(CENTI_TICKS / 150000)};
  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_SCAN = 2'b01,
    ST_HALT = 2'b10
  } poll_state_t;
endpackage
`default_nettype wire

// file: synth_voice_control_poller.sv
// Function
// - one library of 32 user slots, 32 samples of 4 bits each, shared by all voices
// - any of 64 waveforms into A/B
// - 63 noise, 62 fixed shape, 0-31 user, 32-61 silent
// - select carries number and target, immediate
// - mixer 0 gives A, 15 gives B
// - patches turn transpose/mixer into depth
// - volume 0 silent, 15 maximum
// - X/Y 7 centres, corners pick one output
// - four 16-bit timers, 10 ms steps
// - poller scans modules at 4 M/s
// - completed module halts poller, raises interrupt
// - stopped module number readable at address
// - skip flag makes poller pass module
// - ramp endpoint and speed, 4 bits each
// - ramp slides to endpoint at speed, falling volume at half speed
// - timer count 0 to 65535
`timescale 1ns/1ps
`default_nettype none
module synth_voice_control_poller #(
  parameter int unsigned TIMER_STEP_CYCLES = synth_voice_pkg::TIMER_STEP_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [3:0] osc_tick,
  output logic poll_irq,
  output logic [47:0] voice_level_out,
  output logic [127:0] quad_gain_out,
  output logic [15:0] cutoff_out,
  output logic [15:0] transpose_out,
  output logic [15:0] fm_depth_out,
  output logic [15:0] wm_depth_out
);
  import synth_voice_pkg::*;

  typedef struct packed {
    logic [3:0][2:0] osc_sync;
    logic [3:0] osc_level;
    logic [3:0][4:0] phase;
    logic [3:0][5:0] sel_a;
    logic [3:0][5:0] sel_b;
    logic [5:0] load_slot;
    logic [4:0] load_idx;
    logic [23:0][3:0] r_val;
    logic [23:0][3:0] r_end;
    logic [23:0][3:0] r_spd;
    logic [23:0][17:0] r_cnt;
    logic [23:0] r_done;
    logic [3:0][15:0] t_cnt;
    logic [3:0] t_done;
    logic [31:0] t_pre;
    logic [10:0] base_pre;
    logic [5:0] poll_pre;
    poll_state_t st;
    logic poll_en;
    logic [4:0] poll_idx;
    logic [4:0] stopped;
    logic [31:0] skip;
    logic [3:0] fm_patch;
    logic [3:0] wm_patch;
    logic [15:0] lfsr;
    logic dph_wr;
    logic [7:0] dph_addr;
    logic [31:0] rdata;
    logic [3:0][11:0] level;
    logic [3:0][3:0][7:0] quad;
    logic [3:0][3:0] cutoff;
    logic [3:0][3:0] trans;
    logic [3:0][3:0] fmd;
    logic [3:0][3:0] wmd;
  } state_t;

  state_t q, d;
  logic [3:0] wave_lib [USER_SLOTS][SAMPLES];
  logic lib_we;
  logic [31:0] done_vec;
  logic base_tick, tmr_tick, poll_tick, wr;
  logic [4:0] ri;
  logic [17:0] per;
  logic [3:0] smp_a, smp_b, mix_pos, vol, px, py;
  logic [7:0] mix;
  logic [7:0] a_addr;

  function automatic logic [3:0] wave_sample(input logic [5:0] sel, input logic [4:0] idx,
                                             input logic [3:0] noise);
    if (sel == WAVE_NOISE) begin
      return noise;
    end else if (sel == WAVE_RANDOM) begin
      return RANDOM_SHAPE[{idx, 2'b00} +: 4];
    end else if (sel < 6'(USER_SLOTS)) begin
      return wave_lib[sel[4:0]][idx];
    end
    return 4'h0;
  endfunction

  always_comb begin
    d = q;
    lib_we = 1'b0;
    ri = '0;
    per = '0;
    smp_a = '0;
    smp_b = '0;
    mix_pos = '0;
    vol = '0;
    px = '0;
    py = '0;
    mix = '0;
    done_vec = '0;
    a_addr = (haddr[31:8] == 24'h0) ? haddr[7:0] : ADDR_NONE;
    wr = q.dph_wr;
    base_tick = (q.base_pre == '0);
    tmr_tick = (q.t_pre == '0);
    poll_tick = (q.poll_pre == '0);
    d.base_pre = base_tick ? 11'(RAMP_BASE_CYC - 1) : q.base_pre - 11'h1;
    d.t_pre = tmr_tick ? 32'(TIMER_STEP_CYCLES - 1) : q.t_pre - 32'h1;
    d.poll_pre = poll_tick ? 6'(POLL_CYC - 1) : q.poll_pre - 6'h1;
    d.lfsr = {q.lfsr[14:0], ~(q.lfsr[15] ^ q.lfsr[14] ^ q.lfsr[12] ^ q.lfsr[3])};

    for (int v = 0; v < 4; v++) begin
      d.osc_sync[v] = {q.osc_sync[v][1:0], osc_tick[v]};
      if (q.osc_sync[v][1] == q.osc_sync[v][2]) begin
        d.osc_level[v] = q.osc_sync[v][1];
        if (q.osc_sync[v][1] && !q.osc_level[v]) begin
          d.phase[v] = q.phase[v] + 5'h1;
        end
      end
    end

    for (int r = 0; r < 24; r++) begin
      per = {1'b0, RAMP_PERIOD[q.r_spd[r]]};
      if ((r % 6) == int'(P_VOL) && q.r_end[r] < q.r_val[r]) begin
        per = {RAMP_PERIOD[q.r_spd[r]], 1'b0};
      end
      if (base_tick) begin
        if (q.r_cnt[r] == '0) begin
          d.r_cnt[r] = per - 18'h1;
          if (q.r_val[r] < q.r_end[r]) begin
            d.r_val[r] = q.r_val[r] + 4'h1;
          end else if (q.r_val[r] > q.r_end[r]) begin
            d.r_val[r] = q.r_val[r] - 4'h1;
          end
        end else begin
          d.r_cnt[r] = q.r_cnt[r] - 18'h1;
        end
      end
      if (q.r_val[r] == q.r_end[r]) begin
        d.r_done[r] = 1'b1;
      end
    end

    for (int v = 0; v < 4; v++) begin
      if (tmr_tick && q.t_cnt[v] != '0) begin
        d.t_cnt[v] = q.t_cnt[v] - 16'h1;
      end
      if (q.t_cnt[v] == '0) begin
        d.t_done[v] = 1'b1;
      end
      done_vec[v * 8 +: 6] = q.r_done[v * 6 +: 6];
      done_vec[v * 8 + int'(P_TMR)] = q.t_done[v];
    end

    if (wr && q.dph_addr == ADDR_CTRL) begin
      d.poll_en = hwdata[CTRL_EN_BIT];
    end
    if (wr && q.dph_addr == ADDR_SKIP) begin
      d.skip = hwdata;
    end
    if (wr && q.dph_addr == ADDR_PATCH) begin
      d.fm_patch = hwdata[3:0];
      d.wm_patch = hwdata[PATCH_WM_LSB +: 4];
    end
    if (wr && q.dph_addr == ADDR_WSEL) begin
      // any of 64 into A, B or both
      if (hwdata[WSEL_A_BIT]) begin
        d.sel_a[hwdata[VOICE_LSB +: 2]] = hwdata[5:0];
      end
      if (hwdata[WSEL_B_BIT]) begin
        d.sel_b[hwdata[VOICE_LSB +: 2]] = hwdata[5:0];
      end
    end
    if (wr && q.dph_addr == ADDR_WADDR) begin
      d.load_slot = hwdata[WADDR_SLOT_LSB +: 6];
      d.load_idx = '0;
    end
    if (wr && q.dph_addr == ADDR_WDATA) begin
      lib_we = (q.load_slot < 6'(USER_SLOTS));
      d.load_idx = q.load_idx + 5'h1;
    end
    if (wr && q.dph_addr == ADDR_RAMP && hwdata[RAMP_PAR_LSB +: 3] < 3'(RAMPS_PER_VOICE)) begin
      ri = 5'(hwdata[VOICE_LSB +: 2] * 6) + 5'(hwdata[RAMP_PAR_LSB +: 3]);
      d.r_end[ri] = hwdata[3:0];
      d.r_spd[ri] = hwdata[RAMP_SPD_LSB +: 4];
      d.r_cnt[ri] = '0;
      d.r_done[ri] = 1'b0;
    end
    if (wr && q.dph_addr == ADDR_TIMER) begin
      d.t_cnt[hwdata[TIMER_VOICE_LSB +: 2]] = hwdata[15:0];
      d.t_done[hwdata[TIMER_VOICE_LSB +: 2]] = 1'b0;
    end

    case (q.st)
      ST_OFF: begin
        if (q.poll_en) begin
          d.st = ST_SCAN;
        end
      end
      ST_SCAN: begin
        if (!q.poll_en) begin
          d.st = ST_OFF;
        end else if (poll_tick) begin
          if (done_vec[q.poll_idx] && !q.skip[q.poll_idx]) begin
            d.st = ST_HALT;
            d.stopped = q.poll_idx;
          end else begin
            d.poll_idx = q.poll_idx + 5'h1;
          end
        end
      end
      ST_HALT: begin
        if (!q.poll_en) begin
          d.st = ST_OFF;
        end else if (wr && q.dph_addr == ADDR_CTRL && hwdata[CTRL_RESUME_BIT]) begin
          d.st = ST_SCAN;
          d.poll_idx = q.poll_idx + 5'h1;
        end
      end
      default: begin
        d.st = ST_OFF;
      end
    endcase

    for (int v = 0; v < 4; v++) begin
      smp_a = wave_sample(q.sel_a[v], q.phase[v], q.lfsr[3:0]);
      smp_b = wave_sample(q.sel_b[v], q.phase[v], q.lfsr[7:4]);
      mix_pos = q.wm_patch[v] ? MIX_CENTRE : q.r_val[v * 6 + int'(P_MIX)];
      mix = 8'(smp_a * (LEVEL_MAX - mix_pos)) + 8'(smp_b * mix_pos);
      vol = q.r_val[v * 6 + int'(P_VOL)];
      d.level[v] = 12'(mix * vol);
      px = q.r_val[v * 6 + int'(P_X)];
      py = q.r_val[v * 6 + int'(P_Y)];
      // quad weights from X and Y
      d.quad[v][0] = 8'((LEVEL_MAX - px) * (LEVEL_MAX - py));
      d.quad[v][1] = 8'(px * (LEVEL_MAX - py));
      d.quad[v][2] = 8'((LEVEL_MAX - px) * py);
      d.quad[v][3] = 8'(px * py);
      d.cutoff[v] = q.r_val[v * 6 + int'(P_CUT)];
      d.trans[v] = q.fm_patch[v] ? 4'h0 : q.r_val[v * 6 + int'(P_TRN)];
      d.fmd[v] = q.fm_patch[v] ? q.r_val[v * 6 + int'(P_TRN)] : 4'h0;
      d.wmd[v] = q.wm_patch[v] ? q.r_val[v * 6 + int'(P_MIX)] : 4'h0;
    end

    d.dph_wr = 1'b0;
    d.rdata = '0;
    if (hsel && hready && htrans[1]) begin
      d.dph_wr = hwrite;
      d.dph_addr = a_addr;
      if (!hwrite) begin
        case (a_addr)
          ADDR_CTRL: begin
            d.rdata[CTRL_EN_BIT] = q.poll_en;
            d.rdata[CTRL_HALT_BIT] = (q.st == ST_HALT);
          end
          ADDR_STOP: d.rdata[4:0] = q.stopped;
          ADDR_SKIP: d.rdata = q.skip;
          ADDR_PATCH: d.rdata[7:0] = {q.wm_patch, q.fm_patch};
          ADDR_DONE: d.rdata = {4'h0, q.t_done, q.r_done};
          default: d.rdata = '0;
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  always_ff @(posedge hclk) begin
    if (lib_we) begin
      wave_lib[q.load_slot[4:0]][q.load_idx] <= hwdata[3:0];
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = q.rdata;
  assign poll_irq = (q.st == ST_HALT);
  assign voice_level_out = q.level;
  assign quad_gain_out = q.quad;
  assign cutoff_out = q.cutoff;
  assign transpose_out = q.trans;
  assign fm_depth_out = q.fmd;
  assign wm_depth_out = q.wmd;
endmodule // synth_voice_control_poller
`default_nettype wire

// file: synth_voice_poller_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module synth_voice_poller_checker
  import synth_voice_pkg::*;
#(
  parameter int unsigned TIMER_STEP_CYCLES = 20
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic poll_irq,
  input wire logic [47:0] voice_level_out,
  input wire logic [127:0] quad_gain_out
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic rd;
  logic wr_ctrl;
  logic quad_ok;
  logic level_ok;
  logic [1:0] live_q;
  assign rd = hsel && hready && htrans[1] && !hwrite;
  assign wr_ctrl = hsel && hready && htrans[1] && hwrite && haddr == {24'h0, ADDR_CTRL};
  always_comb begin
    quad_ok = 1'b1;
    level_ok = 1'b1;
    for (int v = 0; v < 4; v++) begin
      if (10'(quad_gain_out[32*v+:8]) + 10'(quad_gain_out[32*v+8+:8])
          + 10'(quad_gain_out[32*v+16+:8]) + 10'(quad_gain_out[32*v+24+:8]) != 10'h0E1) begin
        quad_ok = 1'b0;
      end
      if (voice_level_out[12*v+:12] > 12'hD2F) begin
        level_ok = 1'b0;
      end
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      live_q <= 2'h0;
    end else if (live_q != 2'h3) begin
      live_q <= live_q + 2'h1;
    end
  end
  a_rdata_rest: assert property (!rd |=> hrdata == 32'h0)
    else $error("read data not zero outside a read");
  a_stop_width: assert property (rd && haddr == {24'h0, ADDR_STOP} |=> hrdata[31:5] == 27'h0)
    else $error("stop number wider than five bits");
  a_done_width: assert property (rd && haddr == {24'h0, ADDR_DONE} |=> hrdata[31:28] == 4'h0)
    else $error("done flags beyond four timers");
  a_halt_is_irq: assert property (rd && haddr == {24'h0, ADDR_CTRL} |=> hrdata[2] == $past(poll_irq))
    else $error("halted bit differs from interrupt");
  // Disable reaches the state one cycle after the stored enable
  a_irq_cleared: assert property (wr_ctrl ##1 !hwdata[0] |=> ##1 !poll_irq)
    else $error("interrupt stays after disable");
  a_resume_drops: assert property (
    wr_ctrl ##1 (hwdata[1:0] == 2'h3 && poll_irq) |=> !poll_irq)
    else $error("interrupt stays after resume");
  a_irq_fall_cause: assert property (
    $fell(poll_irq) |-> $past(wr_ctrl, 2) || $past(wr_ctrl, 3))
    else $error("interrupt dropped without control write");
  a_quad_sum: assert property (live_q == 2'h3 |-> quad_ok)
    else $error("quad gains do not sum to full level");
  a_level_range: assert property (level_ok)
    else $error("voice level above full scale");
  cover property ($rose(poll_irq));
  cover property (wr_ctrl ##1 hwdata[1:0] == 2'h3);
  cover property (rd && haddr == {24'h0, ADDR_STOP});
endmodule // synth_voice_poller_checker
`default_nettype wire

// file: synth_voice_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module synth_voice_host_model
  import synth_voice_pkg::*;
(
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  output logic [31:0] rd_data,
  output logic rd_tgl
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    rd_data = 32'h0;
    rd_tgl = 1'b0;
  end
  task automatic addr_phase(input logic [31:0] a, input logic w);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (!hready);
    htrans <= 2'h0;
  endtask
  task automatic write(input logic [7:0] a, input logic [31:0] d);
    addr_phase({24'h0, a}, 1'b1);
    hwdata <= d;
    do @(posedge hclk); while (!hready);
    hwdata <= ~d;
  endtask
  task automatic read(input logic [31:0] a);
    addr_phase(a, 1'b0);
    do @(posedge hclk); while (!hready);
    rd_data <= hrdata;
    rd_tgl <= !rd_tgl;
  endtask
  task automatic sel_wave(input logic [1:0] v, input logic [5:0] w, input logic [1:0] ab);
    write(ADDR_WSEL, {18'h0, v, 2'h0, ab, 2'h0, w});
  endtask
  task automatic load_wave(input logic [4:0] slot, input logic [127:0] s);
    write(ADDR_WADDR, 32'(slot) * 32'h40);
    for (int i = 0; i < 32; i++) begin
      write(ADDR_WDATA, {28'h0, s[4*i+:4]});
    end
  endtask
  task automatic start_delay(input logic [1:0] v, input logic [15:0] centi);
    write(ADDR_TIMER, {14'h0, v, centi});
  endtask
endmodule // synth_voice_host_model
`default_nettype wire

// file: synth_voice_control_poller_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module synth_voice_control_poller_tb_top;
  import synth_voice_pkg::*;
  logic hclk = 1'b0;
  logic hresetn, hsel, hwrite, hready, hreadyout, hresp, rd_tgl, poll_irq;
  logic [31:0] haddr, hwdata, hrdata, rd_data;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] osc_tick = 4'h0;
  logic [47:0] voice_level_out;
  logic [127:0] quad_gain_out;
  logic [15:0] cutoff_out, transpose_out, fm_depth_out, wm_depth_out;
  int bad_count, samples_checked, seed, tick_n = 0;
  logic [31:0] d;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  assign hready = hreadyout;
  always #2.5 hclk = ~hclk;
  synth_voice_control_poller #(.TIMER_STEP_CYCLES(20)) uut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .osc_tick(osc_tick), .poll_irq(poll_irq), .voice_level_out(voice_level_out),
    .quad_gain_out(quad_gain_out), .cutoff_out(cutoff_out), .transpose_out(transpose_out),
    .fm_depth_out(fm_depth_out), .wm_depth_out(wm_depth_out));
  synth_voice_host_model u_host (.hclk(hclk), .hready(hready), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .rd_data(rd_data), .rd_tgl(rd_tgl));
  task automatic end_of_test();
    if (bad_count == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic cmp_word(input logic [31:0] g, input logic [31:0] e, input logic [31:0] m);
    samples_checked++;
    if ((g & m) !== (e & m)) begin
      bad_count++;
      $display("[ERR] %0t value %h expected %h", $time, g, e);
    end
  endtask
  task automatic cmp_irq(input logic e, input int n, input int hold);
    int i;
    i = 0;
    while (poll_irq !== e && i < n) begin
      @(posedge hclk);
      i++;
    end
    repeat (hold) @(posedge hclk) if (poll_irq !== e) i = n + 1;
    samples_checked++;
    if (poll_irq !== e || i > n) begin
      bad_count++;
      $display("[ERR] %0t interrupt level not as expected", $time);
    end
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    u_host.read({24'h0, a});
  endtask
  always @(rd_tgl) begin
    if (exp_q.size() != 0) begin
      cmp_word(rd_data, exp_q.pop_front(), msk_q.pop_front());
    end
  end
  always @(posedge hclk) begin
    tick_n <= tick_n + 1;
    if (tick_n % 4 == 0) osc_tick <= 4'($random(seed));
  end
  initial begin
    #100000;
    bad_count++;
    end_of_test();
  end
  initial begin
    seed = 32'hCBA6;
    hresetn = 1'b0;
    bad_count = 0;
    samples_checked = 0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    chk_rd(ADDR_CTRL, 32'h0, 32'hFFFFFFFF);
    chk_rd(ADDR_DONE, 32'h0FFFFFFF, 32'hFFFFFFFF);
    chk_rd(ADDR_STOP, 32'h0, 32'hFFFFFFFF);
    exp_q.push_back(32'h0);
    msk_q.push_back(32'hFFFFFFFF);
    u_host.read(32'h100);
    cmp_word({31'h0, hresp}, 32'h0, 32'hFFFFFFFF);
    chk_rd(ADDR_WSEL, 32'h0, 32'hFFFFFFFF);
    d = $random(seed);
    u_host.write(ADDR_SKIP, d);
    chk_rd(ADDR_SKIP, d, 32'hFFFFFFFF);
    u_host.write(ADDR_PATCH, d & 32'hFF);
    chk_rd(ADDR_PATCH, d & 32'hFF, 32'hFFFFFFFF);
    for (int i = 1; i < 4; i++) u_host.sel_wave(2'(i), 6'h3C + 6'(i), 2'(i));
    u_host.load_wave(5'h05, {$random(seed), $random(seed), $random(seed), $random(seed)});
    u_host.sel_wave(2'h0, 6'h05, 2'h3);
    cmp_word(32'(voice_level_out[47:24] | voice_level_out[23:0]), 32'h0, 32'hFFFFFFFF);
    u_host.start_delay(2'h1, 16'h0003);
    chk_rd(ADDR_DONE, 32'h0, 32'h02000000);
    u_host.start_delay(2'h2, 16'h0000);
    u_host.start_delay(2'h3, 16'hFFFF);
    chk_rd(ADDR_DONE, 32'h04000000, 32'h0C000000);
    u_host.write(ADDR_SKIP, ~32'h4000);
    u_host.write(ADDR_CTRL, 32'h1);
    cmp_irq(1'b1, 1700, 100);
    chk_rd(ADDR_STOP, 32'd14, 32'hFFFFFFFF);
    chk_rd(ADDR_CTRL, 32'h5, 32'h5);
    u_host.write(ADDR_CTRL, 32'h3);
    cmp_irq(1'b0, 2, 1400);
    cmp_irq(1'b1, 300, 0);
    u_host.write(ADDR_SKIP, 32'hFFFFFFFF);
    u_host.write(ADDR_CTRL, 32'h3);
    cmp_irq(1'b0, 2, 2000);
    u_host.write(ADDR_SKIP, 32'h0);
    // Up to three poll ticks: two idle modules can sit in a row
    cmp_irq(1'b1, 160, 0);
    u_host.write(ADDR_CTRL, 32'h0);
    cmp_irq(1'b0, 2, 200);
    // First ramp step lands at the next base tick
    u_host.write(ADDR_PATCH, 32'h21);
    u_host.write(ADDR_RAMP, 32'h01F5);
    u_host.write(ADDR_RAMP, 32'h02F3);
    u_host.write(ADDR_RAMP, 32'h10F4);
    u_host.write(ADDR_RAMP, 32'h24FF);
    chk_rd(ADDR_DONE, 32'h0, 32'h00010046);
    repeat (2100) @(posedge hclk);
    cmp_word({cutoff_out, wm_depth_out}, 32'h0001_0010, 32'hFFFFFFFF);
    cmp_word({transpose_out, fm_depth_out}, 32'h0000_0001, 32'hFFFFFFFF);
    cmp_word(quad_gain_out[95:64], 32'h0000_0FD2, 32'hFFFFFFFF);
    end_of_test();
  end
endmodule // synth_voice_control_poller_tb_top
bind synth_voice_control_poller synth_voice_poller_checker #(
  .TIMER_STEP_CYCLES(TIMER_STEP_CYCLES)
) u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .poll_irq(poll_irq),
  .voice_level_out(voice_level_out), .quad_gain_out(quad_gain_out));
`default_nettype wire
